// ==== core/wavegen_defs.svh ====
/*
 * Register offsets, field positions, reset values and timing figures of the
 * excitation waveform generator.
 * Assumes inclusion by its bare name from the package and the design files.
 */
`ifndef WAVEGEN_DEFS_SVH
`define WAVEGEN_DEFS_SVH

// ****************************************************************
// Register offsets (byte addresses, one 32-bit word each)
// ****************************************************************
`define WG_OFF_FRONTEND   8'h00
`define WG_OFF_WAVECFG    8'h14
`define WG_OFF_LEVEL1     8'h18
`define WG_OFF_LEVEL2     8'h1c
`define WG_OFF_HOLD1      8'h20
`define WG_OFF_RAMP1      8'h24
`define WG_OFF_HOLD2      8'h28
`define WG_OFF_RAMP2      8'h2c
`define WG_OFF_FREQ       8'h30
`define WG_OFF_PHASE      8'h34
`define WG_OFF_COMMON     8'h38
`define WG_OFF_GAIN       8'h3c
`define WG_OFF_DIRECT     8'h40
`define WG_OFF_STATUS     8'h44

// ****************************************************************
// Fields
// ****************************************************************
`define WG_EN_BIT         14
`define WG_TRAP_RST_BIT   0
`define WG_SEL_MSB        2
`define WG_SEL_LSB        1
`define WG_SRC_SINE       2'h2
`define WG_SRC_TRAP       2'h3
`define WG_DAC_W          12
`define WG_TIME_W         19
`define WG_PHASE_W        26
`define WG_GAIN_W         11
`define WG_ROM_AW         5
`define WG_ROM_DW         11
`define WG_SEQ_WRITE_BIT  31
`define WG_SEQ_ADDR_MSB   30
`define WG_SEQ_ADDR_LSB   25
`define WG_SEQ_DATA_MSB   24
`define WG_STAT_SEG_LSB   16
`define WG_STAT_RUN_BIT   20

// ****************************************************************
// Reset values and arithmetic
// ****************************************************************
`define WG_DAC_MID        12'h800
`define WG_STEP_FRAC      16
`define WG_DIV_STEPS      5'h1c

// ****************************************************************
// Timing
// ****************************************************************
`define WG_CLK_PERIOD_PS     10000
`define WG_GUARD_TIME_PS     812500
`define WG_UPDATE_PERIOD_PS  3125000
`define WG_GUARD_CYC ((`WG_GUARD_TIME_PS + `WG_CLK_PERIOD_PS - 1) / `WG_CLK_PERIOD_PS)
`define WG_TICK_CYC  (`WG_UPDATE_PERIOD_PS / `WG_CLK_PERIOD_PS)

`endif

// ==== core/wavegen_pkg.sv ====
/*
 * Types of the excitation waveform generator: trapezoid segments and the
 * packed state records of the modules.
 * Assumes wavegen_defs.svh is on the include path.
 */
`default_nettype none
`include "wavegen_defs.svh"

package wavegen_pkg;

    typedef enum logic [3:0] {
        SEG_HOLD1 = 4'b0001,
        SEG_RAMP1 = 4'b0010,
        SEG_HOLD2 = 4'b0100,
        SEG_RAMP2 = 4'b1000
    } segment_type;

    typedef struct packed {
        logic                    enable;
        logic [1:0]              src_sel;
        logic [1:0]              src_last;
        logic                    running;
        logic                    trap_rst;
        logic [`WG_DAC_W-1:0]    level1;
        logic [`WG_DAC_W-1:0]    level2;
        logic [`WG_TIME_W-1:0]   hold1;
        logic [`WG_TIME_W-1:0]   ramp1;
        logic [`WG_TIME_W-1:0]   hold2;
        logic [`WG_TIME_W-1:0]   ramp2;
        logic [`WG_PHASE_W-1:0]  fcw;
        logic [`WG_PHASE_W-1:0]  start_phase;
        logic [`WG_PHASE_W-1:0]  acc;
        logic [`WG_GAIN_W-1:0]   gain;
        logic [`WG_GAIN_W-1:0]   gain_act;
        logic [`WG_DAC_W-1:0]    common;
        logic [`WG_DAC_W-1:0]    direct;
        logic                    direct_new;
        logic [6:0]              guard_cnt;
        logic [1:0]              sine_vld;
        logic                    sign_d;
        segment_type             seg;
        logic [`WG_TIME_W-1:0]   seg_cnt;
        logic [8:0]              tick_cnt;
        logic [`WG_DAC_W-1:0]    ramp_start;
        logic [`WG_DAC_W-1:0]    ramp_target;
        logic                    ramp_down;
        logic [27:0]             ramp_acc;
        logic [19:0]             div_rem;
        logic [27:0]             div_quo;
        logic [`WG_TIME_W-1:0]   div_dur;
        logic [4:0]              div_cnt;
        logic [`WG_DAC_W-1:0]    dac_code;
        logic [31:0]             rdata;
    } gen_state_type;

    typedef struct packed {
        logic [`WG_ROM_DW-1:0] data;
    } rom_state_type;

endpackage

`default_nettype wire

// ==== core/sine_rom_if.sv ====
/*
 * Connection between the generator and its quarter-wave sine table.
 * Assumes both ends share one clock.
 */
`default_nettype none
`include "wavegen_defs.svh"

interface sine_rom_if;
    logic [`WG_ROM_AW-1:0] addr;
    logic [`WG_ROM_DW-1:0] data;

    modport requester (output addr, input data);
    modport table_side(input addr, output data);
endinterface

`default_nettype wire

// ==== core/sine_rom.sv ====
/*
 * Quarter-wave sine magnitude table, 32 entries of 11 bits, read data
 * registered one cycle after the address.
 * Assumes clk_sys and reset_n of the generator.
 */
`default_nettype none
`include "wavegen_defs.svh"

module sine_rom
    import wavegen_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    sine_rom_if.table_side  rom
);

    localparam logic [`WG_ROM_DW-1:0] TABLE [32] = '{
        11'h032, 11'h097, 11'h0fb, 11'h15e, 11'h1c0, 11'h222, 11'h282, 11'h2e1,
        11'h33e, 11'h398, 11'h3f1, 11'h447, 11'h49b, 11'h4eb, 11'h539, 11'h584,
        11'h5cb, 11'h60e, 11'h64e, 11'h68a, 11'h6c1, 11'h6f5, 11'h724, 11'h74f,
        11'h776, 11'h798, 11'h7b5, 11'h7cd, 11'h7e1, 11'h7f0, 11'h7f9, 11'h7fe
    };

    rom_state_type s;
    rom_state_type n;

    always_comb begin
        n.data = TABLE[rom.addr];
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign rom.data = s.data;

endmodule

`default_nettype wire

// ==== core/excitation_waveform_generator.sv ====
/*
 * Excitation waveform generator: sinusoid, trapezoid and direct DAC codes
 * for the sensor excitation DAC, with a register port and a sequencer
 * command input.
 * Assumes inputs synchronous to clk_sys and a DAC that takes dac_code.
 */
// The implementer's own choices: the register addresses and the plain strobed port.
`default_nettype none
`include "wavegen_defs.svh"

module excitation_waveform_generator
    import wavegen_pkg::*;
#(
    parameter int TICK_CYC  = `WG_TICK_CYC,
    parameter int GUARD_CYC = `WG_GUARD_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        seq_cmd_valid,
    input  wire logic [31:0] seq_cmd,
    output logic             seq_cmd_ready,
    output logic      [11:0] dac_code
);

    gen_state_type s;
    gen_state_type n;
    sine_rom_if    rom_link();

    logic                  wr_en;
    logic [7:0]            wr_addr;
    logic [31:0]           wr_data;
    logic                  go;
    logic                  restart;
    logic                  tick;
    logic [27:0]           step;
    logic [27:0]           acc_nx;
    logic [12:0]           offs;
    logic [`WG_TIME_W-1:0] len;
    logic [`WG_DAC_W-1:0]  from_lvl;
    logic [`WG_DAC_W-1:0]  to_lvl;
    logic [`WG_DAC_W-1:0]  diff;
    logic [19:0]           rem_sh;
    segment_type           seg_nx;
    logic signed [12:0]    smp;
    logic signed [24:0]    prod;
    logic signed [14:0]    sum;
    logic [`WG_DAC_W-1:0]  sine_code;

    sine_rom u_rom (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .rom     (rom_link.table_side)
    );

    // ****************************************************************
    // Sine table addressing with quarter-wave mirroring
    // ****************************************************************
    assign rom_link.addr = s.acc[24] ? ~s.acc[23:19] : s.acc[23:19];

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        n         = s;
        wr_en     = reg_wr | (seq_cmd_valid & seq_cmd[`WG_SEQ_WRITE_BIT]);
        wr_addr   = reg_wr ? reg_addr
                           : {seq_cmd[`WG_SEQ_ADDR_MSB:`WG_SEQ_ADDR_LSB], 2'h0};
        wr_data   = reg_wr ? reg_wdata : {7'h0, seq_cmd[`WG_SEQ_DATA_MSB:0]};
        go        = s.enable;
        restart   = go & (~s.running | (s.src_sel != s.src_last) | s.trap_rst);
        tick      = (s.tick_cnt == 9'h0);
        step      = (s.div_cnt == 5'h0) ? s.div_quo : 28'h0;
        acc_nx    = s.ramp_acc + step;
        offs      = {1'b0, acc_nx[27:`WG_STEP_FRAC]} + {12'h0, acc_nx[`WG_STEP_FRAC-1]};
        len       = s.hold1;
        seg_nx    = SEG_HOLD1;
        from_lvl  = s.level1;
        to_lvl    = s.level2;
        diff      = 12'h0;
        rem_sh    = {s.div_rem[18:0], s.div_quo[27]};

        // Sinusoid sample: table magnitude, sign, gain and common mode.
        smp       = s.sign_d ? -$signed({2'h0, rom_link.data})
                             : $signed({2'h0, rom_link.data});
        prod      = smp * $signed({1'b0, s.gain_act});
        sum       = $signed({3'h0, s.common}) + $signed({prod[24], prod[24:11]});
        if (sum[14]) begin
            sine_code = 12'h0;
        end else if (sum[13:12] != 2'h0) begin
            sine_code = 12'hfff;
        end else begin
            sine_code = sum[11:0];
        end

        n.running    = go;
        n.src_last   = s.src_sel;
        n.trap_rst   = 1'b0;
        n.direct_new = 1'b0;
        n.sign_d     = s.acc[`WG_PHASE_W-1];
        n.sine_vld   = {s.sine_vld[0], 1'b1};
        n.tick_cnt   = tick ? 9'(TICK_CYC - 1) : s.tick_cnt - 9'h1;
        if (s.guard_cnt != 7'h0) begin
            n.guard_cnt = s.guard_cnt - 7'h1;
        end

        // ************************************************************
        // Register read port, data one cycle after the strobe
        // ************************************************************
        n.rdata = 32'h0;
        if (reg_rd) begin
            case (reg_addr)
                `WG_OFF_FRONTEND: n.rdata[`WG_EN_BIT] = s.enable;
                `WG_OFF_WAVECFG:  n.rdata[`WG_SEL_MSB:`WG_SEL_LSB] = s.src_sel;
                `WG_OFF_LEVEL1:   n.rdata = {20'h0, s.level1};
                `WG_OFF_LEVEL2:   n.rdata = {20'h0, s.level2};
                `WG_OFF_HOLD1:    n.rdata = {13'h0, s.hold1};
                `WG_OFF_RAMP1:    n.rdata = {13'h0, s.ramp1};
                `WG_OFF_HOLD2:    n.rdata = {13'h0, s.hold2};
                `WG_OFF_RAMP2:    n.rdata = {13'h0, s.ramp2};
                `WG_OFF_FREQ:     n.rdata = {6'h0, s.fcw};
                `WG_OFF_PHASE:    n.rdata = {6'h0, s.start_phase};
                `WG_OFF_COMMON:   n.rdata = {20'h0, s.common};
                `WG_OFF_GAIN:     n.rdata = {21'h0, s.gain};
                `WG_OFF_DIRECT:   n.rdata = {20'h0, s.direct};
                `WG_OFF_STATUS:   n.rdata = {11'h0, s.running, s.seg, 4'h0, s.dac_code};
                default:          n.rdata = 32'h0;
            endcase
        end

        // ************************************************************
        // Register writes from software or the sequencer
        // ************************************************************
        if (wr_en) begin
            case (wr_addr)
                `WG_OFF_FRONTEND: n.enable = wr_data[`WG_EN_BIT];
                `WG_OFF_WAVECFG: begin
                    n.src_sel  = wr_data[`WG_SEL_MSB:`WG_SEL_LSB];
                    n.trap_rst = wr_data[`WG_TRAP_RST_BIT];
                end
                `WG_OFF_LEVEL1:   n.level1 = wr_data[`WG_DAC_W-1:0];
                `WG_OFF_LEVEL2:   n.level2 = wr_data[`WG_DAC_W-1:0];
                `WG_OFF_HOLD1:    n.hold1  = wr_data[`WG_TIME_W-1:0];
                `WG_OFF_RAMP1:    n.ramp1  = wr_data[`WG_TIME_W-1:0];
                `WG_OFF_HOLD2:    n.hold2  = wr_data[`WG_TIME_W-1:0];
                `WG_OFF_RAMP2:    n.ramp2  = wr_data[`WG_TIME_W-1:0];
                `WG_OFF_FREQ:     n.fcw    = wr_data[`WG_PHASE_W-1:0];
                `WG_OFF_PHASE:    n.start_phase = wr_data[`WG_PHASE_W-1:0];
                `WG_OFF_COMMON:   n.common = wr_data[`WG_DAC_W-1:0];
                `WG_OFF_GAIN:     n.gain   = wr_data[`WG_GAIN_W-1:0];
                `WG_OFF_DIRECT: begin
                    if (s.guard_cnt == 7'h0) begin
                        n.direct     = wr_data[`WG_DAC_W-1:0];
                        n.direct_new = 1'b1;
                        n.guard_cnt  = 7'(GUARD_CYC - 1);
                    end
                end
                default: ;
            endcase
        end

        // ************************************************************
        // Slope step division, one quotient bit per cycle
        // ************************************************************
        if (s.div_cnt != 5'h0) begin
            n.div_cnt = s.div_cnt - 5'h1;
            if (rem_sh >= {1'b0, s.div_dur}) begin
                n.div_rem = rem_sh - {1'b0, s.div_dur};
                n.div_quo = {s.div_quo[26:0], 1'b1};
            end else begin
                n.div_rem = rem_sh;
                n.div_quo = {s.div_quo[26:0], 1'b0};
            end
        end

        // ************************************************************
        // Waveform engines
        // ************************************************************
        if (restart) begin
            n.acc      = s.start_phase;
            n.gain_act = s.gain;
            n.seg      = SEG_HOLD1;
            n.seg_cnt  = '0;
            n.tick_cnt = 9'(TICK_CYC - 1);
            n.sine_vld = 2'h0;
            n.div_cnt  = 5'h0;
            n.div_quo  = 28'h0;
            if (s.src_sel == `WG_SRC_TRAP) begin
                n.dac_code = s.level1;
            end
        end else if (go && s.src_sel == `WG_SRC_SINE) begin
            n.acc = s.acc + s.fcw;
            if (s.sine_vld[1]) begin
                n.dac_code = sine_code;
            end
        end else if (go && s.src_sel == `WG_SRC_TRAP && tick) begin
            case (s.seg)
                SEG_HOLD1: begin
                    len        = s.hold1;
                    seg_nx     = SEG_RAMP1;
                    from_lvl   = s.level1;
                    to_lvl     = s.level2;
                    n.dac_code = s.level1;
                end
                SEG_RAMP1: begin
                    len    = s.ramp1;
                    seg_nx = SEG_HOLD2;
                end
                SEG_HOLD2: begin
                    len        = s.hold2;
                    seg_nx     = SEG_RAMP2;
                    from_lvl   = s.level2;
                    to_lvl     = s.level1;
                    n.dac_code = s.level2;
                end
                SEG_RAMP2: begin
                    len    = s.ramp2;
                    seg_nx = SEG_HOLD1;
                end
                default: begin
                    len    = s.hold1;
                    seg_nx = SEG_HOLD1;
                end
            endcase
            if (s.seg == SEG_RAMP1 || s.seg == SEG_RAMP2) begin
                n.ramp_acc = acc_nx;
                n.dac_code = s.ramp_down ? s.ramp_start - offs[11:0]
                                         : s.ramp_start + offs[11:0];
            end
            if ({1'b0, s.seg_cnt} + 20'h1 >= {1'b0, len}) begin
                if (s.seg == SEG_RAMP1 || s.seg == SEG_RAMP2) begin
                    n.dac_code = s.ramp_target;
                end
                n.seg     = seg_nx;
                n.seg_cnt = '0;
                if (seg_nx == SEG_RAMP1 || seg_nx == SEG_RAMP2) begin
                    diff          = (to_lvl < from_lvl) ? from_lvl - to_lvl : to_lvl - from_lvl;
                    n.ramp_start  = from_lvl;
                    n.ramp_target = to_lvl;
                    n.ramp_down   = to_lvl < from_lvl;
                    n.ramp_acc    = 28'h0;
                    n.div_rem     = 20'h0;
                    n.div_quo     = {diff, 16'h0};
                    n.div_dur     = (seg_nx == SEG_RAMP1) ? s.ramp1 : s.ramp2;
                    n.div_cnt     = `WG_DIV_STEPS;
                end
            end else begin
                n.seg_cnt = s.seg_cnt + 19'h1;
            end
        end else if (!go && (s.trap_rst || s.src_sel != s.src_last)) begin
            // Idle reset of the held code: new source shows its start level.
            n.seg = SEG_HOLD1;
            n.dac_code = (s.src_sel == `WG_SRC_TRAP) ? s.level1
                       : (s.src_sel == `WG_SRC_SINE) ? s.common : s.direct;
        end

        if (!s.src_sel[1] && s.direct_new) begin
            n.dac_code = s.direct;
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s          <= '0;
            s.seg      <= SEG_HOLD1;
            s.level1   <= `WG_DAC_MID;
            s.level2   <= `WG_DAC_MID;
            s.common   <= `WG_DAC_MID;
            s.direct   <= `WG_DAC_MID;
            s.dac_code <= `WG_DAC_MID;
        end else begin
            s <= n;
        end
    end

    assign reg_rdata     = s.rdata;
    assign dac_code      = s.dac_code;
    assign seq_cmd_ready = ~reg_wr;

endmodule

`default_nettype wire

// ==== testbench/excitation_waveform_generator_assertions.sv ====
/*
 * Checker of the excitation waveform generator, bound to its top module.
 * Assumes one clock domain and the port names of the top module.
 */
`default_nettype none

module excitation_waveform_generator_assertions #(
    parameter int GUARD_CYC = 82
) (
    input wire logic        clk_sys,
    input wire logic        reset_n,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic        seq_cmd_valid,
    input wire logic [31:0] seq_cmd,
    input wire logic        seq_cmd_ready,
    input wire logic [11:0] dac_code
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        wr_any;
    logic [7:0]  wa;
    logic [31:0] wd;
    logic        dir_new;
    logic        dir_hit;
    logic        en_q;
    logic [1:0]  src_q;
    logic [6:0]  gap_q;

    // Software and sequencer writes are merged the way the design merges them.
    assign wr_any  = reg_wr | (seq_cmd_valid & seq_cmd[31] & seq_cmd_ready);
    assign wa      = reg_wr ? reg_addr : {seq_cmd[30:25], 2'b00};
    assign wd      = reg_wr ? reg_wdata : {7'h00, seq_cmd[24:0]};
    assign dir_new = wr_any && wa == 8'h40;
    assign dir_hit = dir_new && gap_q >= 7'(GUARD_CYC);

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            en_q  <= 1'b0;
            src_q <= 2'h0;
            gap_q <= 7'h7f;
        end else begin
            if (wr_any && wa == 8'h00)
                en_q <= wd[14];
            if (wr_any && wa == 8'h14)
                src_q <= wd[2:1];
            if (dir_hit)
                gap_q <= 7'h01;
            else if (gap_q != 7'h7f)
                gap_q <= gap_q + 7'h01;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    ready_follows_a: assert property (seq_cmd_ready == !reg_wr)
        else $error("sequencer ready does not follow the write strobe");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside a read answer");
    status_read_a: assert property (reg_rd && reg_addr == 8'h44 |=>
        reg_rdata[11:0] == $past(dac_code)) else $error("status shows a wrong code");
    unmapped_read_a: assert property (reg_rd && reg_addr > 8'h44 |=> reg_rdata == 32'h0)
        else $error("unmapped read returned data");
    direct_lands_a: assert property (dir_hit && !src_q[1] |-> ##2
        dac_code == $past(wd[11:0], 2)) else $error("direct code did not land");
    guard_drop_a: assert property (dir_new && !dir_hit && gap_q >= 7'h02 && !src_q[1]
        |=> $stable(dac_code)[*2]) else $error("direct write inside guard was taken");
    held_off_a: assert property ((!en_q && !wr_any)[*6] |=> $stable(dac_code))
        else $error("code moved while generator disabled");
    reset_code_a: assert property ($rose(reset_n) |-> dac_code == 12'h800)
        else $error("code after reset is not midscale");

    cover property (dir_hit ##2 1'b1);
    cover property (dir_new && !dir_hit);
    cover property (en_q && src_q == 2'h3);
endmodule

bind excitation_waveform_generator excitation_waveform_generator_assertions #(
    .GUARD_CYC(GUARD_CYC)) i_chk (.clk_sys(clk_sys), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .seq_cmd_valid(seq_cmd_valid), .seq_cmd(seq_cmd),
    .seq_cmd_ready(seq_cmd_ready), .dac_code(dac_code));

`default_nettype wire

// ==== testbench/dac_model.sv ====
/*
 * Model of the excitation DAC: takes a code each clock and counts changes.
 * Assumes the code is sampled at the rising clock edge.
 */
`default_nettype none

module dac_model (
    input  wire logic        clk_sys,
    input  wire logic [11:0] dac_code,
    output var  int          n_changes
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] last_code;

    always @(posedge clk_sys) begin
        if (dac_code !== last_code)
            n_changes <= n_changes + 1;
        last_code <= dac_code;
    end
endmodule

`default_nettype wire

// ==== testbench/excitation_waveform_generator_tb_top.sv ====
/*
 * Self-checking bench of the excitation waveform generator.
 * Assumes the design, the checker and the DAC model are compiled first.
 */
`default_nettype none

module excitation_waveform_generator_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, reset_n, reg_wr, reg_rd, seq_cmd_valid, seq_cmd_ready;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, seq_cmd, x;
    logic [11:0] dac_code, la, lb;
    int          n_changes, bad_count, n_compared, n0;
    int          mreg [int];
    int          adr [10] = '{'h18, 'h1c, 'h20, 'h24, 'h28, 'h2c, 'h30, 'h34, 'h38, 'h3c};
    int          msk [10] = '{'hfff, 'hfff, 'h7ffff, 'h7ffff, 'h7ffff, 'h7ffff,
                              'h3ffffff, 'h3ffffff, 'hfff, 'h7ff};

    excitation_waveform_generator #(.TICK_CYC(4), .GUARD_CYC(4))
        i_excitation_waveform_generator (.clk_sys(clk_sys), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .seq_cmd_valid(seq_cmd_valid), .seq_cmd(seq_cmd),
        .seq_cmd_ready(seq_cmd_ready), .dac_code(dac_code));
    dac_model i_dac_model (.clk_sys(clk_sys), .dac_code(dac_code), .n_changes(n_changes));

    // ****************************************************************
    // Bus tasks and comparison
    // ****************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        mreg[a] = v;
    endtask

    task automatic seqw(input logic [7:0] a, input logic [24:0] v);
        @(posedge clk_sys);
        seq_cmd_valid <= 1'b1;
        seq_cmd       <= {1'b1, a[7:2], v};
        @(posedge clk_sys);
        seq_cmd_valid <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        chk(reg_rdata, e);
    endtask

    // Waits a bounded number of cycles for a code, then compares.
    task automatic waitdac(input logic [11:0] e, input int n);
        repeat (n) begin
            @(negedge clk_sys);
            if (dac_code === e)
                break;
        end
        chk(32'(dac_code), 32'(e));
    endtask

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (30000) @(posedge clk_sys);
        bad_count++;
        complete_run();
    end

    initial begin
        {reset_n, reg_wr, reg_rd, seq_cmd_valid} = 4'h0;
        reg_addr  = 8'h00;
        reg_wdata = 32'h0;
        seq_cmd   = 32'h0;
        void'($urandom(32'h3ec35eed));
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        waitdac(12'h800, 1);
        rd(8'h00, 32'h0);
        foreach (adr[i]) begin
            wr(adr[i][7:0], $urandom & msk[i]);
            rd(adr[i][7:0], mreg[adr[i]]);
        end
        rd(8'h4c, 32'h0);
        // Direct codes: the second write falls inside the guard, the third not.
        wr(8'h14, 32'h0);
        la = 12'($urandom);
        lb = la ^ 12'h5a5;
        wr(8'h40, {20'h0, la});
        wr(8'h40, {20'h0, lb});
        repeat (2) @(negedge clk_sys);
        chk(32'(dac_code), 32'(la));
        seqw(8'h40, {13'h0, lb});
        waitdac(lb, 4);
        rd(8'h44, 32'h10000 | lb);
        // Sine with zero gain sits on the common-mode level.
        wr(8'h14, 32'h4);
        wr(8'h38, 32'h600);
        wr(8'h3c, 32'h0);
        wr(8'h30, 32'h0);
        wr(8'h34, 32'h0400000);
        wr(8'h00, 32'h4000);
        waitdac(12'h600, 12);
        wr(8'h3c, 32'h200);
        repeat (12) @(negedge clk_sys);
        chk(32'(dac_code), 32'h600);
        wr(8'h00, 32'h0);
        wr(8'h00, 32'h4000);
        repeat (12) @(negedge clk_sys);
        x = 32'(dac_code);
        chk(32'(x > 32'h600), 32'h1);
        wr(8'h38, 32'h610);
        repeat (12) @(negedge clk_sys);
        chk(32'(dac_code), x + 32'h10);
        n0 = n_changes;
        wr(8'h30, 32'h0100000);
        repeat (40) @(negedge clk_sys);
        chk(32'(n_changes - n0 > 20), 32'h1);
        x = 32'(dac_code);
        repeat (32) @(negedge clk_sys);
        chk(32'(dac_code != x), 32'h1);
        repeat (32) @(negedge clk_sys);
        chk(32'(dac_code), x);
        seqw(8'h00, 25'h0);
        repeat (8) @(negedge clk_sys);
        n0 = n_changes;
        repeat (30) @(negedge clk_sys);
        chk(n_changes, n0);
        // Trapezoid with a long second hold, entered by a live source change.
        wr(8'h18, {20'h0, la});
        wr(8'h1c, {20'h0, lb});
        wr(8'h20, 32'h0);
        wr(8'h24, 32'h1);
        wr(8'h28, 32'd20);
        wr(8'h2c, 32'h1);
        wr(8'h00, 32'h4000);
        wr(8'h14, 32'h6);
        waitdac(la, 8);
        waitdac(lb, 300);
        waitdac(la, 300);
        waitdac(lb, 300);
        wr(8'h14, 32'h7);
        waitdac(la, 8);
        complete_run();
    end
endmodule

`default_nettype wire
